// File: adc_fmt_pkg.sv
// Shared constants and types of the converter output formatter.
package adc_fmt_pkg;

  // Datapath sizing.
  localparam int DATA_W = 14;
  localparam int FIFO_DEPTH = 16;

  // Serial configuration word layout.
  localparam int FRAME_BITS = 16;
  localparam int HDR_BITS = 8;
  localparam int CNT_W = 5;

  // Register offsets on the serial port.
  localparam logic [6:0] ADDR_RESET = 7'h00;
  localparam logic [6:0] ADDR_FORMAT = 7'h04;

  // Field positions.
  localparam int SRST_BIT = 7;
  localparam int PAT_MSB = 5;
  localparam int PAT_LSB = 3;
  localparam int POL_BIT = 2;
  localparam int SCR_BIT = 1;
  localparam int TWOS_BIT = 0;

  // Reset value of the format register.
  localparam logic [7:0] FORMAT_RESET = 8'h00;

  // Test pattern selector codes.
  localparam logic [2:0] PAT_OFF = 3'h0;
  localparam logic [2:0] PAT_ZEROS = 3'h1;
  localparam logic [2:0] PAT_ONES = 3'h3;
  localparam logic [2:0] PAT_CHECKER = 3'h5;
  localparam logic [2:0] PAT_TOGGLE = 3'h7;

  // Checkerboard first phase: overflow then data bits.
  localparam logic [DATA_W:0] CHECKER_WORD = 15'h5555;

  // Serial port sequencing.
  typedef enum logic [1:0] {SPI_IDLE, SPI_SHIFT, SPI_DONE} spi_state_e;

  // One output sample: overflow flag above the data bits.
  typedef struct packed {
    logic overflow_flag;
    logic [DATA_W-1:0] data;
  } sample_s;

endpackage : adc_fmt_pkg

// File: adc_output_data_formatter.sv
// Output data formatter with serial format register and sample FIFO.
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////
module sample_fifo #(
  parameter int WIDTH = 15,
  parameter int DEPTH = 16
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic nrst,
  // Filling side.
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Draining side.
  input wire logic out_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr_q;
  logic [AW:0] rd_ptr_q;
  logic push;
  logic pop;

  // Extra pointer bit tells full from empty when the indices meet.
  assign out_valid = wr_ptr_q != rd_ptr_q;
  assign in_ready = !((wr_ptr_q[AW] != rd_ptr_q[AW])
                      && (wr_ptr_q[AW-1:0] == rd_ptr_q[AW-1:0]));
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_ptr_q[AW-1:0]];

  // Storage has no reset; only the pointers define what is valid.
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wr_ptr_q[AW-1:0]] <= in_data;
    end
  end

  // Pointer movement.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
    end
  end
endmodule : sample_fifo

////////////////////////////////////////////////////////////////////////////
module adc_output_data_formatter #(
  parameter int FIFO_DEPTH = adc_fmt_pkg::FIFO_DEPTH
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic nrst,
  // Serial configuration port; data out is open drain.
  input wire logic cs_n,
  input wire logic sck,
  input wire logic sdi,
  input wire logic sdo_i,
  output logic sdo_o,
  output logic sdo_oe,
  // Conversion words in.
  input wire logic sample_valid,
  output logic sample_ready,
  input wire adc_fmt_pkg::sample_s sample_in,
  // Formatted words out to the receiver.
  output logic out_valid,
  input wire logic out_ready,
  output adc_fmt_pkg::sample_s out_word
);
  import adc_fmt_pkg::*;

  spi_state_e spi_state_q;
  logic sck_q;
  logic sck_rise;
  logic [CNT_W-1:0] bit_cnt_q;
  logic [FRAME_BITS-1:0] shift_q;
  logic [FRAME_BITS-1:0] frame;
  logic hdr_done;
  logic frame_done;
  logic wr_commit;
  logic rd_commit;
  logic srst;
  logic [7:0] rd_shift_q;
  logic rd_act_q;
  logic [7:0] format_q;
  logic [7:0] rd_value;
  logic fifo_valid;
  logic take;
  logic phase_q;
  sample_s head;
  sample_s out_q;
  logic out_valid_q;

  ////////////////////////////////////////////////////////////////////////
  // Serial configuration port.
  // Pins are synchronous to core_clk, so a registered copy finds edges.
  assign sck_rise = sck && !sck_q;
  assign frame = {shift_q[FRAME_BITS-2:0], sdi};
  assign hdr_done = sck_rise && (spi_state_q == SPI_SHIFT)
                    && (bit_cnt_q == CNT_W'(HDR_BITS - 1));
  assign frame_done = sck_rise && (spi_state_q == SPI_SHIFT)
                      && (bit_cnt_q == CNT_W'(FRAME_BITS - 1));
  assign wr_commit = frame_done && !frame[FRAME_BITS-1];
  assign rd_commit = frame_done && frame[FRAME_BITS-1];
  assign srst = wr_commit && (frame[14:8] == ADDR_RESET)
                && frame[SRST_BIT];

  // Reset register is write only and reads as zero.
  always_comb begin
    rd_value = 8'h00;
    if ({shift_q[5:0], sdi} == ADDR_FORMAT) begin
      rd_value = format_q;
    end
  end

  // Frame sequencing; edges after the sixteenth are ignored.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      spi_state_q <= SPI_IDLE;
      sck_q <= 1'b0;
      bit_cnt_q <= '0;
      shift_q <= '0;
    end else begin
      sck_q <= sck;
      unique case (spi_state_q)
        SPI_IDLE: begin
          bit_cnt_q <= '0;
          if (!cs_n) begin
            spi_state_q <= SPI_SHIFT;
          end
        end
        SPI_SHIFT: begin
          if (cs_n) begin
            spi_state_q <= SPI_IDLE;
          end else if (sck_rise) begin
            shift_q <= frame;
            bit_cnt_q <= bit_cnt_q + 1'b1;
            if (frame_done) begin
              spi_state_q <= SPI_DONE;
            end
          end
        end
        SPI_DONE: begin
          if (cs_n) begin
            spi_state_q <= SPI_IDLE;
          end
        end
      endcase
    end
  end

  // Read back: after the header the register is shifted out MSB first.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rd_shift_q <= 8'h00;
      rd_act_q <= 1'b0;
    end else if (cs_n) begin
      rd_act_q <= 1'b0;
    end else if (hdr_done && shift_q[6]) begin
      rd_shift_q <= rd_value;
      rd_act_q <= 1'b1;
    end else if (sck_rise && rd_act_q) begin
      rd_shift_q <= {rd_shift_q[6:0], 1'b0};
      rd_act_q <= !frame_done;
    end
  end

  // Open drain: only ever pulls low, the board pull-up gives the ones.
  assign sdo_o = 1'b0;
  assign sdo_oe = rd_act_q && !rd_shift_q[7];

  // Format register; a read frame never writes it.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      format_q <= FORMAT_RESET;
    end else if (srst) begin
      format_q <= FORMAT_RESET;
    end else if (wr_commit && (frame[14:8] == ADDR_FORMAT)) begin
      format_q <= frame[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sample path.
  sample_fifo #(
    .WIDTH($bits(sample_s)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .core_clk(core_clk),
    .nrst(nrst),
    .in_valid(sample_valid),
    .in_ready(sample_ready),
    .in_data(sample_in),
    .out_ready(take),
    .out_valid(fifo_valid),
    .out_data(head)
  );

  // Shapes one word. Coding first, then polarity, then scrambling, so the
  // receiver undoes them in reverse order.
  function automatic sample_s shape(input sample_s s, input logic [7:0] f,
                                    input logic ph);
    sample_s r;
    r = s;
    if (f[TWOS_BIT] && !f[POL_BIT]) begin
      r.data[DATA_W-1] = !s.data[DATA_W-1];
    end
    for (int i = 1; i < DATA_W; i += 2) begin
      r.data[i] = r.data[i] ^ f[POL_BIT];
    end
    if (f[SCR_BIT]) begin
      r.data[DATA_W-1:1] = r.data[DATA_W-1:1]
                           ^ {(DATA_W-1){r.data[0]}};
    end
    // Test patterns replace everything, overflow flag included.
    unique case (f[PAT_MSB:PAT_LSB])
      PAT_OFF: r = r;
      PAT_ZEROS: r = '0;
      PAT_ONES: r = '1;
      PAT_CHECKER: r = ph ? ~CHECKER_WORD : CHECKER_WORD;
      PAT_TOGGLE: r = ph ? '1 : '0;
      default: r = r;
    endcase
    return r;
  endfunction : shape

  // Output stage stalls the FIFO while the receiver holds off.
  assign take = fifo_valid && (!out_valid_q || out_ready);

  // Registered output word; the pattern phase advances once per sample.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      out_q <= '0;
      out_valid_q <= 1'b0;
      phase_q <= 1'b0;
    end else begin
      if (take) begin
        out_q <= shape(head, format_q, phase_q);
        phase_q <= !phase_q;
        out_valid_q <= 1'b1;
      end else if (out_ready) begin
        out_valid_q <= 1'b0;
      end
    end
  end

  assign out_valid = out_valid_q;
  assign out_word = out_q;

  ////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  chk_pass_normal: assert property (
    take && (format_q == 8'h00) |=> out_q == $past(head))
    else $error("normal data altered with all modes off");
  chk_zero_pattern: assert property (
    take && (format_q[PAT_MSB:PAT_LSB] == 3'h1) |=> out_q == 15'h0000)
    else $error("zero pattern not all zero");
  chk_ones_pattern: assert property (
    take && (format_q[PAT_MSB:PAT_LSB] == 3'h3) |=> out_q == 15'h7fff)
    else $error("ones pattern not all one");
  chk_checker_alt: assert property (
    take && (format_q[PAT_MSB:PAT_LSB] == 3'h5) |=>
    (out_q == 15'h5555) || (out_q == 15'h2aaa))
    else $error("checkerboard word wrong");
  chk_checker_flip: assert property (
    take && (format_q[PAT_MSB:PAT_LSB] == 3'h5) ##1
    (take && (format_q[PAT_MSB:PAT_LSB] == 3'h5))
    |=> out_q == ~$past(out_q))
    else $error("checkerboard did not alternate");
  chk_toggle_pat: assert property (
    take && (format_q[PAT_MSB:PAT_LSB] == 3'h7) ##1
    (take && (format_q[PAT_MSB:PAT_LSB] == 3'h7))
    |=> ((out_q == 15'h0000) || (out_q == 15'h7fff))
        && (out_q != $past(out_q)))
    else $error("toggle pattern did not toggle");
  chk_twos_coding: assert property (
    take && (format_q == 8'h01) |=>
    out_q == ($past(head) ^ 15'h2000))
    else $error("two's complement coding wrong");
  chk_pol_forces_ob: assert property (
    take && (format_q == 8'h05) |=>
    out_q == ($past(head) ^ 15'h2aaa))
    else $error("polarity mode did not force offset binary");
  chk_scramble_xor: assert property (
    take && (format_q == 8'h02) |=>
    (out_q.data[DATA_W-1:1] == ($past(head.data[DATA_W-1:1])
      ^ {(DATA_W-1){$past(head.data[0])}}))
    && (out_q.data[0] == $past(head.data[0])))
    else $error("scrambled word wrong");
  chk_soft_reset: assert property (
    srst |=> format_q == 8'h00)
    else $error("software reset left format bits set");
  chk_read_keeps: assert property (
    rd_commit |=> $stable(format_q))
    else $error("read frame changed the format register");
  chk_frame_len: assert property (
    (spi_state_q == SPI_SHIFT) && !cs_n && sck_rise
    |-> bit_cnt_q < CNT_W'(FRAME_BITS))
    else $error("more than sixteen bits taken in a frame");
  cov_format_write: cover property (wr_commit
    && (frame[14:8] == ADDR_FORMAT));
  cov_read_back: cover property (rd_commit);
  cov_fifo_full: cover property (sample_valid && !sample_ready);
  cov_checker_run: cover property (take
    && (format_q[PAT_MSB:PAT_LSB] == 3'h5) ##1 take [*2]);

endmodule : adc_output_data_formatter

// File: rx_model.sv
// Receiver model that captures formatted words and can stall.
`timescale 1ns/100ps
module rx_model (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic nrst,
  // Word stream from the formatter.
  input wire logic out_valid,
  output logic out_ready,
  input wire adc_fmt_pkg::sample_s out_word,
  // Pace: 0 prompt, 1 every other cycle, 2 stopped.
  input wire logic [1:0] mode
);
  import adc_fmt_pkg::*;
  sample_s q[$];
  logic tgl_q;
  // Ready moves just after the edge, as a registered receiver would.
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      out_ready <= 1'b0;
      tgl_q <= 1'b0;
    end else begin
      if (out_valid && out_ready) q.push_back(out_word);
      tgl_q <= !tgl_q;
      out_ready <= #1 (mode == 2'h0) || (mode == 2'h1 && tgl_q);
    end
  end
endmodule : rx_model

// File: tb.sv
// Self-checking bench of the output formatter.
`timescale 1ns/100ps
module tb;
  import adc_fmt_pkg::*;
  localparam int DEPTH = 16;
  logic core_clk, nrst, cs_n, sck, sdi, sdo_o, sdo_oe;
  logic sample_valid, sample_ready, out_valid, out_ready;
  logic [1:0] mode;
  logic [7:0] rd;
  sample_s sample_in, out_word, w;
  int errors, checks_done, cyc, nw, np;
  wire logic sdo_pin;
  // Only defined selector codes are programmed.
  logic [7:0] fmts [10] = '{8'h00, 8'h08, 8'h18, 8'h28, 8'h38,
    8'h04, 8'h02, 8'h01, 8'h05, 8'h03};
  assign sdo_pin = !sdo_oe; // Pull-up holds the idle line high.
  adc_output_data_formatter #(.FIFO_DEPTH(DEPTH)) i_dut (
    .core_clk(core_clk), .nrst(nrst), .cs_n(cs_n), .sck(sck), .sdi(sdi),
    .sdo_i(sdo_pin), .sdo_o(sdo_o), .sdo_oe(sdo_oe),
    .sample_valid(sample_valid), .sample_ready(sample_ready),
    .sample_in(sample_in), .out_valid(out_valid), .out_ready(out_ready),
    .out_word(out_word));
  rx_model i_rx (.core_clk(core_clk), .nrst(nrst), .out_valid(out_valid),
    .out_ready(out_ready), .out_word(out_word), .mode(mode));
  ////////////////////////////////////////////////////////////////////////
  // Free-running 125 MHz clock.
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = !core_clk;
  end
  // A hang is cut short well past the expected run length.
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      complete_run();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  function automatic sample_s gen(int k);
    return sample_s'(15'(32'h4a5c + k * 32'h0b3d));
  endfunction : gen
  // Expected word for a sample under a format value and pattern phase.
  function automatic sample_s shape(sample_s s, logic [7:0] f, logic ph);
    sample_s r;
    r = s;
    case (f[5:3])
      PAT_ZEROS: r = '0;
      PAT_ONES: r = '1;
      PAT_CHECKER: r = ph ? ~CHECKER_WORD : CHECKER_WORD;
      PAT_TOGGLE: r = {15{ph}};
      default: begin
        if (f[0] && !f[2]) r.data[13] = !r.data[13];
        if (f[2]) r.data = r.data ^ 14'h2aaa;
        if (f[1]) r.data[13:1] = r.data[13:1] ^ {13{r.data[0]}};
      end
    endcase
    return r;
  endfunction : shape
  task automatic cmp_reg(logic [7:0] got, logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp_reg
  task automatic cmp_word(sample_s got, sample_s exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp_word
  task automatic tick(int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tick
  // One serial frame of n bits; read data is taken before rises 9 to 16.
  task automatic xfer(logic [15:0] x, int n);
    rd = '0;
    cs_n = 1'b0;
    tick(2);
    for (int i = 0; i < n; i++) begin
      sdi = x[15-i];
      tick(2);
      if (i >= 8) rd[15-i] = sdo_pin;
      sck = 1'b1;
      tick(2);
      sck = 1'b0;
    end
    tick(2);
    cs_n = 1'b1;
    tick(2);
  endtask : xfer
  // Read with all-ones on the data line, which must be ignored.
  task automatic rdchk(logic [6:0] a, logic [7:0] e);
    xfer({1'b1, a, 8'hff}, 16);
    cmp_reg(rd, e);
    cmp_reg({7'h0, sdo_pin}, 8'h01);
    cmp_reg({7'h0, sdo_o}, 8'h00);
  endtask : rdchk
  // Valid is left high so back-to-back pushes never drop it between words.
  task automatic push(sample_s s);
    sample_valid = 1'b1;
    sample_in = s;
    for (int i = 0; i < 100 && sample_ready !== 1'b1; i++) tick(1);
    tick(1);
  endtask : push
  task automatic drain(logic [7:0] f);
    for (int i = 0; i < 300 && i_rx.q.size() < np - nw; i++) tick(1);
    cmp_reg(8'(i_rx.q.size()), 8'(np - nw));
    while (i_rx.q.size() > 0) begin
      w = i_rx.q.pop_front();
      cmp_word(w, shape(gen(nw), f, nw[0]));
      nw++;
    end
  endtask : drain
  task automatic complete_run();
    $display("errors %0d checks %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : complete_run
  ////////////////////////////////////////////////////////////////////////
  // Main sequence of register and sample scenarios.
  initial begin
    nrst = 1'b0;
    cs_n = 1'b1;
    sck = 1'b0;
    sdi = 1'b0;
    sample_valid = 1'b0;
    sample_in = '0;
    mode = 2'h0;
    repeat (12) @(posedge core_clk);
    #1;
    nrst = 1'b1;
    tick(1);
    rdchk(ADDR_FORMAT, FORMAT_RESET);
    foreach (fmts[k]) begin
      xfer({1'b0, ADDR_FORMAT, fmts[k]}, 16);
      rdchk(ADDR_FORMAT, fmts[k]);
      // Patterns run with a prompt receiver so samples leave back to back.
      mode = (k < 5) ? 2'h0 : 2'h1;
      for (int j = 0; j < 5; j++) begin
        push(gen(np));
        np++;
      end
      sample_valid = 1'b0;
      drain(fmts[k]);
    end
    rdchk(ADDR_FORMAT, 8'h03);
    xfer({1'b0, ADDR_FORMAT, 8'h28}, 10);
    rdchk(ADDR_FORMAT, 8'h03);
    xfer({1'b0, 7'h05, 8'h55}, 16);
    rdchk(7'h05, 8'h00);
    rdchk(ADDR_FORMAT, 8'h03);
    xfer({1'b0, ADDR_RESET, 8'h80}, 16);
    rdchk(ADDR_FORMAT, 8'h00);
    rdchk(ADDR_RESET, 8'h00);
    // Stalled receiver: buffer plus output register fill, then drain slowly.
    mode = 2'h2;
    tick(2);
    for (int j = 0; j < 40 && sample_ready === 1'b1; j++) begin
      push(gen(np));
      np++;
    end
    sample_valid = 1'b0;
    cmp_reg(8'(np - nw), 8'(DEPTH + 1));
    mode = 2'h1;
    drain(8'h00);
    complete_run();
  end
endmodule : tb
